/* hw/ces_consts.svh */
// Constants for the execution-semantics unit: opcodes, steps, limits.
// Assumes inclusion by bare name from the package or module files.
`ifndef CES_CONSTS_SVH
`define CES_CONSTS_SVH
`define CES_OP_TWOS_COMP      8'h03
`define CES_OP_MEM_WRITE_AINC 8'hc2
`define CES_OP_BLOCK_MOVE     8'hc1
`define CES_OP_BLOCK_MOVE_INT 8'hcd
`define CES_OP_RESERVED       8'hee
`define CES_MOST_NEG_WORD     16'h8000
`define CES_PTR_STEP          16'h0002
`define CES_COUNT_MAX         16'h3fff
`define CES_WORD_ZERO         16'h0000
`define CES_ADDR_STEP         16'h0002
`endif

/* hw/ces_pkg.sv */
// Types shared by the execution-semantics unit.
// Assumes the constants header sits beside this file.
package ces_pkg;
  // Execution states of the unit
  typedef enum logic [2:0] {
    CES_IDLE,
    CES_WRITE,
    CES_MOVE,
    CES_DONE
  } ces_state_e;
endpackage

/* hw/ces_exec.sv */
// Execution-semantics unit of a 16-bit controller core: auto-increment
// write, word negate with flags, reserved-opcode trap, block move.
// Assumes the decoder presents one instruction per i_start pulse, with
// operands read from the register file on the same clock.
//
// Summary of operation
// RULE_01: Address from old pointer; increment after completion.
// RULE_02: Self-pointer write stores original pointer value.
// RULE_03: Negating 8000h gives 8000h, sign and overflow.
// RULE_04: Reserved opcode EEH always raises unimplemented trap.
// RULE_05: Block move takes long source/destination pair.
// RULE_06: Block move performs sixteen-bit count transfers. The code clips counts above 3fffh to 3fffh.
// RULE_07: Software keeps count within 0000h to 3fffh.
`timescale 1ns/1ps
`include "ces_consts.svh"
module ces_exec
  import ces_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Instruction issue
  input  wire logic        i_start,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [15:0] i_operand,
  input  wire logic [15:0] i_pointer,
  input  wire logic        i_src_is_ptr,
  input  wire logic [31:0] i_block_address_pair_reg,
  input  wire logic [15:0] i_transfer_count_reg,
  // Memory write and read ports
  output logic             o_mem_write,
  output logic      [15:0] o_mem_addr,
  output logic      [15:0] o_mem_data,
  output logic             o_mem_read,
  output logic      [15:0] o_mem_read_addr,
  // Results
  output logic      [15:0] o_result,
  output logic             o_result_valid,
  output logic             o_flag_sign,
  output logic             o_flag_overflow,
  output logic             o_flag_zero,
  output logic      [15:0] o_ptr_update,
  output logic             o_ptr_update_valid,
  output logic             o_unimpl_trap,
  output logic             o_done
);

  // Word negate producing result and overflow
  function automatic logic [16:0] ces_negate(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000 - v;
    return {(v == `CES_MOST_NEG_WORD), r};
  endfunction

  ces_state_e  state;             // Execution state
  ces_state_e  next_state;
  logic [15:0] ptr_old;           // Pointer latched at issue
  logic [15:0] next_ptr_old;
  logic [15:0] data_hold;         // Data to be written
  logic [15:0] next_data_hold;
  logic [15:0] src_addr;          // Block source address
  logic [15:0] next_src_addr;
  logic [15:0] dst_addr;          // Block destination address
  logic [15:0] next_dst_addr;
  logic [15:0] count;             // Transfers remaining
  logic [15:0] next_count;
  logic        rd_phase;          // Block move: read then write
  logic        next_rd_phase;
  logic        next_mem_write;
  logic [15:0] next_mem_addr;
  logic [15:0] next_mem_data;
  logic        next_mem_read;
  logic [15:0] next_mem_read_addr;
  logic [15:0] next_result;
  logic        next_result_valid;
  logic        next_flag_sign;
  logic        next_flag_overflow;
  logic        next_flag_zero;
  logic [15:0] next_ptr_update;
  logic        next_ptr_update_valid;
  logic        next_unimpl_trap;
  logic        next_done;
  logic [16:0] neg;               // Negate output

  // Next-state and output computation
  always_comb begin
    next_state            = state;
    next_ptr_old          = ptr_old;
    next_data_hold        = data_hold;
    next_src_addr         = src_addr;
    next_dst_addr         = dst_addr;
    next_count            = count;
    next_rd_phase         = rd_phase;
    next_mem_write        = 1'b0;
    next_mem_addr         = o_mem_addr;
    next_mem_data         = o_mem_data;
    next_mem_read         = 1'b0;
    next_mem_read_addr    = o_mem_read_addr;
    next_result           = o_result;
    next_result_valid     = 1'b0;
    next_flag_sign        = o_flag_sign;
    next_flag_overflow    = o_flag_overflow;
    next_flag_zero        = o_flag_zero;
    next_ptr_update       = o_ptr_update;
    next_ptr_update_valid = 1'b0;
    next_unimpl_trap      = 1'b0;
    next_done             = 1'b0;
    neg                   = ces_negate(i_operand);
    case (state)
      CES_IDLE: begin
        if (i_start) begin
          case (i_opcode)
            // Reserved code traps, nothing executes
            `CES_OP_RESERVED: begin
              next_unimpl_trap = 1'b1;  // [RULE_04]
              next_done        = 1'b1;
            end
            // Negate; 8000h keeps its value, sets sign and overflow
            `CES_OP_TWOS_COMP: begin
              next_result        = neg[15:0];
              next_flag_sign     = neg[15];  // [RULE_03]
              next_flag_overflow = neg[16];  // [RULE_03]
              next_flag_zero     = (neg[15:0] == `CES_WORD_ZERO);
              next_result_valid  = 1'b1;
              next_done          = 1'b1;
            end
            // Write through pointer; latch old pointer and data now
            `CES_OP_MEM_WRITE_AINC: begin
              next_ptr_old   = i_pointer;  // [RULE_01]
              next_data_hold = i_src_is_ptr ? i_pointer : i_operand;  // [RULE_02]
              next_state     = CES_WRITE;
            end
            // Block move from long address pair and word count
            `CES_OP_BLOCK_MOVE, `CES_OP_BLOCK_MOVE_INT: begin
              next_src_addr = i_block_address_pair_reg[15:0];   // [RULE_05]
              next_dst_addr = i_block_address_pair_reg[31:16];  // [RULE_05]
              // Counts above the supported range are clipped [RULE_07]
              next_count    = (i_transfer_count_reg > `CES_COUNT_MAX) ?
                              `CES_COUNT_MAX : i_transfer_count_reg;  // [RULE_06]
              next_rd_phase = 1'b1;
              next_state    = CES_MOVE;
            end
            // Other opcodes belong to other units
            default: begin
              next_done = 1'b1;
            end
          endcase
        end
      end
      // Memory write at the old pointer address
      CES_WRITE: begin
        next_mem_write = 1'b1;
        next_mem_addr  = ptr_old;  // [RULE_01]
        next_mem_data  = data_hold;  // [RULE_02]
        next_state     = CES_DONE;
      end
      // One read then one write per transfer
      CES_MOVE: begin
        if (count == `CES_WORD_ZERO) begin
          next_done  = 1'b1;
          next_state = CES_IDLE;
        end else if (rd_phase) begin
          next_mem_read      = 1'b1;
          next_mem_read_addr = src_addr;
          next_rd_phase      = 1'b0;
        end else begin
          next_mem_write = 1'b1;
          next_mem_addr  = dst_addr;
          next_src_addr  = src_addr + `CES_ADDR_STEP;
          next_dst_addr  = dst_addr + `CES_ADDR_STEP;
          next_count     = count - 16'h0001;  // [RULE_06]
          next_rd_phase  = 1'b1;
        end
      end
      // Pointer written back only after the store finished
      CES_DONE: begin
        next_ptr_update       = ptr_old + `CES_PTR_STEP;  // [RULE_01]
        next_ptr_update_valid = 1'b1;
        next_done             = 1'b1;
        next_state            = CES_IDLE;
      end
      default: begin
        next_state = CES_IDLE;
      end
    endcase
  end

  // State and output registers
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state              <= CES_IDLE;
      ptr_old            <= 16'h0000;
      data_hold          <= 16'h0000;
      src_addr           <= 16'h0000;
      dst_addr           <= 16'h0000;
      count              <= 16'h0000;
      rd_phase           <= 1'b0;
      o_mem_write        <= 1'b0;
      o_mem_addr         <= 16'h0000;
      o_mem_data         <= 16'h0000;
      o_mem_read         <= 1'b0;
      o_mem_read_addr    <= 16'h0000;
      o_result           <= 16'h0000;
      o_result_valid     <= 1'b0;
      o_flag_sign        <= 1'b0;
      o_flag_overflow    <= 1'b0;
      o_flag_zero        <= 1'b0;
      o_ptr_update       <= 16'h0000;
      o_ptr_update_valid <= 1'b0;
      o_unimpl_trap      <= 1'b0;
      o_done             <= 1'b0;
    end else begin
      state              <= next_state;
      ptr_old            <= next_ptr_old;
      data_hold          <= next_data_hold;
      src_addr           <= next_src_addr;
      dst_addr           <= next_dst_addr;
      count              <= next_count;
      rd_phase           <= next_rd_phase;
      o_mem_write        <= next_mem_write;
      o_mem_addr         <= next_mem_addr;
      o_mem_data         <= next_mem_data;
      o_mem_read         <= next_mem_read;
      o_mem_read_addr    <= next_mem_read_addr;
      o_result           <= next_result;
      o_result_valid     <= next_result_valid;
      o_flag_sign        <= next_flag_sign;
      o_flag_overflow    <= next_flag_overflow;
      o_flag_zero        <= next_flag_zero;
      o_ptr_update       <= next_ptr_update;
      o_ptr_update_valid <= next_ptr_update_valid;
      o_unimpl_trap      <= next_unimpl_trap;
      o_done             <= next_done;
    end
  end

endmodule

/* tb/ces_exec_sva.sv */
// Checker for the execution-semantics unit, bound to its ports.
// Assumes one clock domain and that i_start comes only while idle.
`timescale 1ns/1ps
module ces_exec_sva (
  // Clock, reset and issue
  input wire logic        i_sys_clk, i_reset, i_start, i_src_is_ptr,
  input wire logic [7:0]  i_opcode,
  input wire logic [15:0] i_operand, i_pointer, i_transfer_count_reg,
  input wire logic [31:0] i_block_address_pair_reg,
  // Outputs watched
  input wire logic        o_mem_write, o_mem_read, o_flag_sign, o_flag_overflow,
  input wire logic        o_ptr_update_valid, o_unimpl_trap, o_done,
  input wire logic [15:0] o_mem_addr, o_mem_data, o_mem_read_addr, o_result, o_ptr_update
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Issue of a store or a block move
  wire st = i_start && (i_opcode == 8'hc2);
  wire mv = i_start && (i_opcode == 8'hc1 || i_opcode == 8'hcd);
  AST_STORE_ORDER: assert property (st |-> ##2 o_mem_write && o_mem_addr == $past(i_pointer, 2)
    ##1 o_ptr_update_valid && o_done && o_ptr_update == $past(i_pointer, 3) + 16'h0002)
    else $error("store address or pointer update wrong");
  AST_SELF_DATA: assert property (st && i_src_is_ptr |-> ##2 o_mem_data == $past(i_pointer, 2))
    else $error("self store wrote the stepped pointer");
  AST_NEG_MIN: assert property (i_start && i_opcode == 8'h03 && i_operand == 16'h8000
    |=> o_result == 16'h8000 && o_flag_sign && o_flag_overflow) else $error("negate of 8000 wrong");
  AST_TRAP: assert property (i_start && i_opcode == 8'hee |=> o_unimpl_trap && o_done)
    else $error("reserved opcode gave no trap");
  AST_TRAP_ONLY: assert property (o_unimpl_trap |-> $past(i_start) && $past(i_opcode) == 8'hee)
    else $error("trap without reserved opcode");
  AST_MOVE_ADDR: assert property (mv && i_transfer_count_reg != 16'h0000 |-> ##2 o_mem_read
    && o_mem_read_addr == $past(i_block_address_pair_reg[15:0], 2) ##1 o_mem_write
    && o_mem_addr == $past(i_block_address_pair_reg[31:16], 3)) else $error("move address wrong");
  AST_MOVE_COUNT: assert property (mv && i_transfer_count_reg == 16'h0003
    |=> !o_done [*7] ##1 o_done) else $error("move of three took wrong time");
  // Main scenarios
  cover property (st && i_src_is_ptr);
  cover property (mv && i_transfer_count_reg == 16'h0003);
  cover property (o_unimpl_trap);
endmodule
bind ces_exec ces_exec_sva u_sva (.*);

/* tb/ces_exec_tb.sv */
// Testbench for the execution-semantics unit: store, negate, trap, move.
// Assumes the checker is bound to the unit by its own file.
`timescale 1ns/1ps
module ces_exec_tb;
  // Design inputs
  logic        i_sys_clk, i_reset, i_start, i_src_is_ptr;
  logic [7:0]  i_opcode;
  logic [15:0] i_operand, i_pointer, i_transfer_count_reg;
  logic [31:0] i_block_address_pair_reg;
  // Design outputs
  logic        o_mem_write, o_mem_read, o_result_valid, o_flag_sign, o_flag_overflow;
  logic        o_flag_zero, o_ptr_update_valid, o_unimpl_trap, o_done;
  logic [15:0] o_mem_addr, o_mem_data, o_mem_read_addr, o_result, o_ptr_update;
  // Counters and captures of one operation
  int          num_errors = 0;
  int          total_checks = 0;
  int          n_rd, n_wr, cyc, pv_n, rv_n;
  logic [15:0] rd_a, wr_a, wr_d;
  logic        trap;
  ces_exec dut (.*);
  // Clock at 100 MHz
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Issue one opcode, then watch outputs until completion, bounded
  task run(input logic [7:0] op);
    int n;
    @(posedge i_sys_clk);
    i_start  <= 1'b1;
    i_opcode <= op;
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    n_rd = 0;
    n_wr = 0;
    trap = 1'b0;
    cyc  = 0;
    pv_n = 0;
    rv_n = 0;
    // Pass n looks at what the edge n cycles after the issue edge samples
    for (n = 1; n <= 40 && cyc == 0; n++) begin
      #1;
      if (o_mem_read === 1'b1) begin
        if (n_rd == 0) rd_a = o_mem_read_addr;
        n_rd++;
      end
      if (o_mem_write === 1'b1) begin
        if (n_wr == 0) begin
          wr_a = o_mem_addr;
          wr_d = o_mem_data;
        end
        n_wr++;
      end
      if (o_unimpl_trap === 1'b1) trap = 1'b1;
      if (o_ptr_update_valid === 1'b1) pv_n = n;
      if (o_result_valid === 1'b1) rv_n = n;
      // Stop on completion; otherwise wait for the next edge
      if (o_done === 1'b1) cyc = n;
      else @(posedge i_sys_clk);
    end
    if (cyc == 0) begin
      num_errors++;
      $display("mismatch at %0t: no completion", $time);
      test_done;
    end
  endtask
  // Store of the pointer through itself with step
  task t_store;
    @(posedge i_sys_clk);
    i_pointer    <= 16'h1000;
    i_src_is_ptr <= 1'b1;
    run(8'hc2);
    check(wr_a, 16'h1000);
    check(wr_d, 16'h1000);
    check(o_ptr_update, 16'h1002);
    check(16'(cyc), 16'h0003);
    check(16'(pv_n), 16'h0003);
    // Store of another register keeps its own data
    @(posedge i_sys_clk);
    i_pointer    <= 16'h2000;
    i_operand    <= 16'h5a5a;
    i_src_is_ptr <= 1'b0;
    run(8'hc2);
    check(wr_a, 16'h2000);
    check(wr_d, 16'h5a5a);
    check(o_ptr_update, 16'h2002);
    $display("test store ended");
  endtask
  // Negate of the most negative word, then of one
  task t_neg;
    @(posedge i_sys_clk);
    i_operand <= 16'h8000;
    run(8'h03);
    check(o_result, 16'h8000);
    check(16'(rv_n), 16'h0001);
    check(16'({o_flag_sign, o_flag_overflow, o_flag_zero, trap}), 16'h000c);
    @(posedge i_sys_clk);
    i_operand <= 16'h0001;
    run(8'h03);
    check(o_result, 16'hffff);
    check(16'({o_flag_sign, o_flag_overflow, o_flag_zero}), 16'h0004);
    $display("test negate ended");
  endtask
  // Reserved opcode
  task t_trap;
    run(8'hee);
    check(16'({trap, 8'(cyc)}), 16'h0101);
    $display("test trap ended");
  endtask
  // Both move forms with three transfers, then an empty move
  task t_move;
    logic [7:0] ops [2] = '{8'hc1, 8'hcd};
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      i_block_address_pair_reg <= 32'h2000_1000;
      i_transfer_count_reg     <= 16'h0003;  // Count kept in range
      run(ops[k]);
      check(rd_a, 16'h1000);
      check(wr_a, 16'h2000);
      check({8'(n_rd), 8'(n_wr)}, 16'h0303);
      check(16'(cyc), 16'h0008);
    end
    @(posedge i_sys_clk);
    i_transfer_count_reg <= 16'h0000;  // Lowest count allowed
    run(8'hc1);
    check({8'(n_wr), 8'(cyc)}, 16'h0002);
    $display("test move ended");
  endtask
  initial begin
    i_reset = 1'b1; i_start = 1'b0; i_opcode = 8'h00; i_src_is_ptr = 1'b0;
    i_operand = 16'h0000; i_pointer = 16'h0000; i_transfer_count_reg = 16'h0000;
    i_block_address_pair_reg = 32'h0000_0000;
    repeat (16) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_store;
    t_neg;
    t_trap;
    t_move;
    test_done;
  end
endmodule
